/* hw/rssx_pkg.sv */
package rssx_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BUS_AW = 8;
  localparam int PRESC_W = 8;
  localparam int WDOG_W = 8;

  // Clocks per instruction cycle, one per phase code
  localparam int PHASES_PER_CYCLE = 4;

  // Opcode fields
  localparam logic [5:0] ROT_OPC = 6'h0c;
  localparam logic [4:0] LSUB_OPC = 5'h1e;
  localparam logic [13:0] SLEEP_WORD = 14'h0063;
  localparam int DEST_BIT = 7;

  // Register map
  localparam logic [7:0] ADDR_ACCUM = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_WDOG = 8'h02;
  localparam logic [7:0] ADDR_PRESC = 8'h03;
  localparam int FILE_SEL_BIT = 7;

  // Status fields
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PWRDN_N = 3;
  localparam int ST_TMO_N = 4;

  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [7:0] WDOG_CLEAR_VAL = 8'h00;
  localparam logic [7:0] PRESC_CLEAR_VAL = 8'h00;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_READ = 2'b01,
    PH_EXEC = 2'b10,
    PH_WRITE = 2'b11
  } rssx_phase_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ROT = 2'b01,
    OP_LSUB = 2'b10,
    OP_SLEEP = 2'b11
  } rssx_op_e;

  typedef struct packed {
    rssx_phase_e phase;
    rssx_op_e op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] lit;
    logic [7:0] fdata;
    logic [7:0] w;
    logic c;
    logic nib_c;
    logic z;
    logic tmo_n;
    logic pwrdn_n;
    logic sleeping;
    logic [7:0] rdata;
    logic rd_file;
  } rssx_state_s;

  localparam rssx_state_s STATE_RESET = '{
    phase: PH_FETCH, op: OP_NONE, dest: 1'b0, faddr: 7'h00, lit: 8'h00,
    fdata: 8'h00, w: ACCUM_RESET, c: 1'b0, nib_c: 1'b0, z: 1'b0,
    tmo_n: 1'b1, pwrdn_n: 1'b1, sleeping: 1'b0, rdata: 8'h00, rd_file: 1'b0
  };

  function automatic rssx_op_e decode_op(input logic [13:0] instr);
    if (instr[13:8] == ROT_OPC) begin
      decode_op = OP_ROT;
    end else if (instr[13:9] == LSUB_OPC) begin
      decode_op = OP_LSUB;
    end else if (instr == SLEEP_WORD) begin
      decode_op = OP_SLEEP;
    end else begin
      decode_op = OP_NONE;
    end
  endfunction : decode_op

  // Returns {carry_out, result}
  function automatic logic [8:0] rot_right(input logic [7:0] f, input logic cin);
    rot_right = {f[0], cin, f[7:1]};
  endfunction : rot_right

  // Returns {carry, nibble_carry, zero, result}; carry is the inverted borrow
  function automatic logic [10:0] lit_minus(input logic [7:0] k, input logic [7:0] w);
    logic [7:0] res;
    res = k - w;
    lit_minus = {(k >= w), (k[3:0] >= w[3:0]), (res == 8'h00), res};
  endfunction : lit_minus

endpackage : rssx_pkg

/* hw/rssx_file_ram.sv */
`timescale 1ns/1ps
module rssx_file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  input wire logic b_we,
  input wire logic b_re,
  input wire logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Execution port wins a write collision on the same word
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we && !(a_we && a_addr == b_addr)) begin
      mem[b_addr] <= b_wdata;
    end
    a_rdata <= mem[a_addr];
    if (b_re) begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule : rssx_file_ram

/* hw/rssx_wdog.sv */
`timescale 1ns/1ps
module rssx_wdog
  import rssx_pkg::*;
#(
  parameter int PW = PRESC_W,
  parameter int CW = WDOG_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  output logic [CW-1:0] count,
  output logic [PW-1:0] presc,
  output logic overflow
);

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [CW-1:0] count;
  } rssx_wd_s;

  rssx_wd_s q;
  rssx_wd_s d;

  // Free running so that it can end a sleep with the oscillator stopped
  always_comb begin
    d = q;
    overflow = (&q.presc) && (&q.count);
    if (clear) begin
      d.presc = PW'(PRESC_CLEAR_VAL);
      d.count = CW'(WDOG_CLEAR_VAL);
    end else begin
      d.presc = q.presc + 1'b1;
      if (&q.presc) begin
        d.count = q.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.count;
  assign presc = q.presc;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_wdog_clear_zero: assert property (clear |=> count == '0 && presc == '0 ##1 presc == 1)
    else $error("watchdog not cleared by sleep");

endmodule : rssx_wdog

/* hw/rssx_exec.sv */
// Function
// - Rotate right through carry, carry into bit7
// - Destination zero: result to accumulator only
// - Destination one: result back to file
// - Literal minus accumulator updates carry, nibble, zero
// - Literal subtract writes accumulator, never file
// - Carry set unless difference negative
// - Sleep clears power-down flag
// - Sleep sets timeout flag
// - Sleep clears watchdog counter and prescaler
// - Sleep opcode enters sleep, halts oscillator
`timescale 1ns/1ps
module rssx_exec
  import rssx_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [rssx_pkg::INSTR_W-1:0] INSTR,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  output logic INSTR_DONE,
  input wire logic WAKE,
  output logic OSC_HALT,
  output logic TIMEOUT_FLAG_N,
  output logic POWERDOWN_FLAG_N,
  output logic [rssx_pkg::DATA_W-1:0] ACCUM,
  input wire logic [rssx_pkg::BUS_AW-1:0] BUS_ADDR,
  input wire logic [rssx_pkg::DATA_W-1:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [rssx_pkg::DATA_W-1:0] BUS_RDATA
);

  import rssx_pkg::*;

  rssx_state_s q;
  rssx_state_s d;

  logic accept;
  logic commit;
  logic [8:0] rot;
  logic [10:0] sub;
  logic [6:0] ram_a_addr;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_a_rdata;
  logic [7:0] ram_b_rdata;
  logic bus_file;
  logic wdog_clear;
  logic wdog_ovf;
  logic [7:0] wdog_count;
  logic [7:0] wdog_presc;

  function automatic logic is_file(input logic [7:0] addr);
    is_file = addr[FILE_SEL_BIT];
  endfunction : is_file

  assign bus_file = is_file(BUS_ADDR);

  // Read address follows the incoming word so data lands in the read phase
  assign ram_a_addr = (q.phase == PH_FETCH) ? INSTR[FADDR_W-1:0] : q.faddr;

  rssx_file_ram #(
    .AW(FADDR_W),
    .DW(DATA_W)
  ) rssx_file_ram_inst (
    .clk(CLK),
    .a_addr(ram_a_addr),
    .a_we(ram_we),
    .a_wdata(ram_wdata),
    .a_rdata(ram_a_rdata),
    .b_addr(BUS_ADDR[FADDR_W-1:0]),
    .b_we(BUS_WR && bus_file),
    .b_re(BUS_RD && bus_file),
    .b_wdata(BUS_WDATA),
    .b_rdata(ram_b_rdata)
  );

  rssx_wdog #(
    .PW(PRESC_W),
    .CW(WDOG_W)
  ) rssx_wdog_inst (
    .clk(CLK),
    .reset(RESET),
    .clear(wdog_clear),
    .count(wdog_count),
    .presc(wdog_presc),
    .overflow(wdog_ovf)
  );

  always_comb begin
    d = q;
    ram_we = 1'b0;
    ram_wdata = 8'h00;
    wdog_clear = 1'b0;
    accept = INSTR_VALID && (q.phase == PH_FETCH) && !q.sleeping;
    commit = (q.phase == PH_WRITE) && (q.op != OP_NONE);
    rot = rot_right(q.fdata, q.c);
    sub = lit_minus(q.lit, q.w);

    // Software writes first so a same-cycle instruction result overrides them
    if (BUS_WR && !bus_file) begin
      if (BUS_ADDR == ADDR_ACCUM) begin
        d.w = BUS_WDATA;
      end else if (BUS_ADDR == ADDR_STATUS) begin
        d.c = BUS_WDATA[ST_CARRY];
        d.nib_c = BUS_WDATA[ST_NIBBLE];
        d.z = BUS_WDATA[ST_ZERO];
      end
    end

    d.rdata = 8'h00;
    d.rd_file = BUS_RD && bus_file;
    if (BUS_RD && !bus_file) begin
      if (BUS_ADDR == ADDR_ACCUM) begin
        d.rdata = q.w;
      end else if (BUS_ADDR == ADDR_STATUS) begin
        d.rdata = {3'h0, q.tmo_n, q.pwrdn_n, q.z, q.nib_c, q.c};
      end else if (BUS_ADDR == ADDR_WDOG) begin
        d.rdata = wdog_count;
      end else if (BUS_ADDR == ADDR_PRESC) begin
        d.rdata = wdog_presc;
      end
    end

    // Phases freeze while the oscillator is halted
    if (q.sleeping) begin
      d.phase = PH_FETCH;
      if (WAKE || wdog_ovf) begin
        d.sleeping = 1'b0;
      end
    end else begin
      d.phase = rssx_phase_e'(q.phase + 2'h1);
    end

    // A watchdog timeout drops the timeout flag
    if (wdog_ovf) begin
      d.tmo_n = 1'b0;
    end

    if (accept) begin
      d.op = decode_op(INSTR);
      d.dest = INSTR[DEST_BIT];
      d.faddr = INSTR[FADDR_W-1:0];
      d.lit = INSTR[7:0];
    end

    if (q.phase == PH_READ) begin
      d.fdata = ram_a_rdata;
    end

    if (commit) begin
      d.op = OP_NONE;
      unique case (q.op)
        OP_ROT: begin
          d.c = rot[8];
          if (q.dest) begin
            ram_we = 1'b1;
            ram_wdata = rot[7:0];
          end else begin
            d.w = rot[7:0];
          end
        end
        OP_LSUB: begin
          d.w = sub[7:0];
          d.c = sub[10];
          d.nib_c = sub[9];
          d.z = sub[8];
        end
        OP_SLEEP: begin
          d.pwrdn_n = 1'b0;
          d.tmo_n = 1'b1;
          wdog_clear = 1'b1;
          d.sleeping = 1'b1;
        end
        OP_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign INSTR_READY = (q.phase == PH_FETCH) && !q.sleeping;
  assign INSTR_DONE = commit;
  assign OSC_HALT = q.sleeping;
  assign TIMEOUT_FLAG_N = q.tmo_n;
  assign POWERDOWN_FLAG_N = q.pwrdn_n;
  assign ACCUM = q.w;
  // Read data stand only in the cycle after the strobe
  assign BUS_RDATA = q.rd_file ? ram_b_rdata : q.rdata;

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence seq_commit_rot;
    commit && q.op == OP_ROT;
  endsequence

  sequence seq_commit_lsub;
    commit && q.op == OP_LSUB;
  endsequence

  sequence seq_commit_sleep;
    commit && q.op == OP_SLEEP;
  endsequence

  chk_rot_carry_in: assert property (seq_commit_rot |=>
      q.c == $past(q.fdata[0]) && {$past(q.c), $past(q.fdata[7:1])} ==
      (($past(q.dest)) ? rssx_file_ram_inst.mem[$past(q.faddr)] : q.w))
    else $error("rotate result or carry wrong");

  chk_rot_to_accum: assert property ((seq_commit_rot and q.dest == 1'b0) |->
      !ram_we ##1 q.w == {$past(q.c), $past(q.fdata[7:1])})
    else $error("rotate to accumulator wrong");

  chk_rot_to_file: assert property ((seq_commit_rot and q.dest == 1'b1) |->
      ram_we && ram_a_addr == q.faddr ##1 $stable(q.w))
    else $error("rotate to file wrong");

  chk_lsub_flags: assert property (seq_commit_lsub |=>
      q.w == 8'($past(q.lit) - $past(q.w)) && q.z == (q.w == 8'h00) &&
      q.nib_c == ($past(q.lit[3:0]) >= $past(q.w[3:0])))
    else $error("literal subtract value or flags wrong");

  chk_lsub_no_file: assert property (seq_commit_lsub |-> !ram_we)
    else $error("literal subtract wrote a file register");

  chk_lsub_carry: assert property (seq_commit_lsub |=>
      q.c == ($past(q.lit) >= $past(q.w)))
    else $error("literal subtract carry wrong");

  chk_sleep_pwrdn_low: assert property (seq_commit_sleep |=> !POWERDOWN_FLAG_N)
    else $error("sleep left power-down flag set");

  chk_sleep_tmo_high: assert property (seq_commit_sleep |->
      wdog_clear ##1 TIMEOUT_FLAG_N)
    else $error("sleep did not set timeout flag");

  chk_sleep_osc_halt: assert property (seq_commit_sleep |=>
      OSC_HALT && !INSTR_READY && wdog_count == 8'h00)
    else $error("sleep did not halt oscillator");

  chk_one_cycle_done: assert property ((accept && decode_op(INSTR) != OP_NONE) |->
      !INSTR_DONE [*3] ##1 INSTR_DONE)
    else $error("instruction not done in one cycle");

  chk_bus_read_slot: assert property ((BUS_RD && BUS_ADDR == ADDR_ACCUM) |=>
      BUS_RDATA == $past(q.w))
    else $error("bus read data wrong");

  // Status read shows the flags as they stood in the strobe cycle
  chk_status_read: assert property ((BUS_RD && BUS_ADDR == ADDR_STATUS) |=>
      BUS_RDATA == {3'h0, $past(TIMEOUT_FLAG_N), $past(POWERDOWN_FLAG_N), $past(q.z),
      $past(q.nib_c), $past(q.c)})
    else $error("status read data wrong");

  chk_bus_rdata_idle: assert property (!BUS_RD |=> BUS_RDATA == 8'h00)
    else $error("read data outside their slot");

  sequence seq_wake;
    OSC_HALT && WAKE;
  endsequence

  // Wake is only looked at while halted
  chk_wake_resumes: assert property (seq_wake |=>
      !OSC_HALT && INSTR_READY)
    else $error("wake did not restart the core");

  chk_halt_no_issue: assert property (OSC_HALT |-> !INSTR_READY && !INSTR_DONE)
    else $error("instruction activity while halted");

  chk_sleep_no_file: assert property (seq_commit_sleep |-> !ram_we)
    else $error("sleep wrote a file register");

  chk_done_one_pulse: assert property (INSTR_DONE |=> !INSTR_DONE)
    else $error("done longer than one cycle");

  chk_ready_spacing: assert property (INSTR_READY |=> !INSTR_READY [*3])
    else $error("instruction taken more than once per cycle");

  chk_unknown_no_effect: assert property ((q.phase == PH_WRITE && q.op == OP_NONE) |->
      !ram_we && !wdog_clear && !INSTR_DONE)
    else $error("unrecognised word had an effect");

  // Rotate touches only the carry among the flags
  chk_rot_flags_kept: assert property ((seq_commit_rot and
      !(BUS_WR && BUS_ADDR == ADDR_STATUS)) |=>
      q.z == $past(q.z) && q.nib_c == $past(q.nib_c))
    else $error("rotate changed zero or nibble carry");

  chk_rot_file_data: assert property ((seq_commit_rot and q.dest == 1'b1) |->
      ram_wdata == {q.c, q.fdata[7:1]})
    else $error("rotate file data wrong");

  chk_ovf_drops_timeout: assert property ((wdog_ovf && !(commit && q.op == OP_SLEEP)) |=>
      !TIMEOUT_FLAG_N)
    else $error("watchdog overflow left timeout flag set");

endmodule : rssx_exec

/* bench/rssx_exec_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module rssx_exec_tb;
  import rssx_pkg::*;
  logic clk = 1'b0;
  logic reset;
  logic [13:0] instr;
  logic ivalid;
  logic iready;
  logic idone;
  logic wake;
  logic halt;
  logic tmo_n;
  logic pwrdn_n;
  logic [7:0] accum;
  logic [7:0] baddr;
  logic [7:0] bwdata;
  logic bwr;
  logic brd;
  logic [7:0] brdata;
  logic [7:0] rd;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  // Last pair aims the literal at file 0x85 to catch a stray write
  logic [7:0] ks [5] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'h85};
  logic [7:0] ws [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h04};

  always #20 clk = ~clk;

  rssx_exec rssx_exec_inst (.CLK(clk), .RESET(reset), .INSTR(instr), .INSTR_VALID(ivalid),
    .INSTR_READY(iready), .INSTR_DONE(idone), .WAKE(wake), .OSC_HALT(halt),
    .TIMEOUT_FLAG_N(tmo_n), .POWERDOWN_FLAG_N(pwrdn_n), .ACCUM(accum), .BUS_ADDR(baddr),
    .BUS_WDATA(bwdata), .BUS_WR(bwr), .BUS_RD(brd), .BUS_RDATA(brdata));

  task end_sim;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog overflow needs 65536 cycles, so the ceiling sits well above it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count++;
      end_sim();
    end
  end

  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bwr <= 1'b1;
    baddr <= a;
    bwdata <= d;
    @(posedge clk);
    bwr <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    brd <= 1'b1;
    baddr <= a;
    @(posedge clk);
    brd <= 1'b0;
    @(negedge clk);
    d = brdata;
  endtask : bus_rd

  // Holds the word offered until the fetch phase takes it
  task exec(input logic [13:0] w, input logic done_exp);
    int n;
    n = 0;
    @(posedge clk);
    instr <= w;
    ivalid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (iready !== 1'b1 && n < 20);
    `CHK("ready", 1'b1, iready)
    @(posedge clk);
    ivalid <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("done early", 1'b0, idone)
    @(negedge clk);
    `CHK("done", done_exp, idone)
    @(negedge clk);
  endtask : exec

  task t_reset;
    @(negedge clk);
    `CHK("accum", 8'h00, accum)
    `CHK("tmo_n", 1'b1, tmo_n)
    `CHK("pwrdn_n", 1'b1, pwrdn_n)
    `CHK("halt", 1'b0, halt)
    `CHK("ready", 1'b1, iready)
    bus_rd(ADDR_STATUS, rd);
    `CHK("status", 5'h18, rd[4:0])
    @(negedge clk);
    `CHK("rdata idle", 8'h00, brdata)
  endtask : t_reset

  task t_rotate;
    bus_wr(8'h85, 8'he6);
    bus_wr(ADDR_STATUS, 8'h00);
    exec(14'h0c05, 1'b1);
    `CHK("rot w", 8'h73, accum)
    bus_rd(8'h85, rd);
    `CHK("rot src", 8'he6, rd)
    bus_rd(ADDR_STATUS, rd);
    `CHK("rot c0", 1'b0, rd[0])
    bus_wr(8'h85, 8'h01);
    bus_wr(ADDR_STATUS, 8'h01);
    exec(14'h0c85, 1'b1);
    bus_rd(8'h85, rd);
    `CHK("rot f", 8'h80, rd)
    `CHK("rot keep w", 8'h73, accum)
    bus_rd(ADDR_STATUS, rd);
    `CHK("rot c1", 1'b1, rd[0])
  endtask : t_rotate

  task t_lsub;
    logic [7:0] r;
    for (int i = 0; i < 5; i++) begin
      bus_wr(ADDR_ACCUM, ws[i]);
      exec({5'h1e, i[0], ks[i]}, 1'b1);
      r = ks[i] - ws[i];
      `CHK("lsub w", r, accum)
      bus_rd(ADDR_STATUS, rd);
      `CHK("lsub c", ks[i] >= ws[i], rd[0])
      `CHK("lsub nibble", ks[i][3:0] >= ws[i][3:0], rd[1])
      `CHK("lsub z", r == 8'h00, rd[2])
    end
    bus_rd(8'h85, rd);
    `CHK("lsub file", 8'h80, rd)
  endtask : t_lsub

  task t_other;
    exec(14'h0000, 1'b0);
    exec(14'h0064, 1'b0);
    `CHK("other w", 8'h81, accum)
    `CHK("other halt", 1'b0, halt)
  endtask : t_other

  task t_sleep;
    int n;
    n = 0;
    while (tmo_n !== 1'b0 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    `CHK("wdog ovf", 1'b0, tmo_n)
    exec(SLEEP_WORD, 1'b1);
    `CHK("halt", 1'b1, halt)
    `CHK("asleep", 1'b0, iready)
    `CHK("pwrdn_n", 1'b0, pwrdn_n)
    `CHK("tmo_n", 1'b1, tmo_n)
    bus_rd(ADDR_WDOG, rd);
    `CHK("wdog", 8'h00, rd)
    // Prescaler restarts at the sleep edge and has counted three clocks by the read
    bus_rd(ADDR_PRESC, rd);
    `CHK("presc", 8'h03, rd)
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    @(negedge clk);
    `CHK("woken", 1'b0, halt)
    `CHK("ready after wake", 1'b1, iready)
  endtask : t_sleep

  initial begin
    reset = 1'b1;
    instr = 14'h0000;
    ivalid = 1'b0;
    wake = 1'b0;
    baddr = 8'h00;
    bwdata = 8'h00;
    bwr = 1'b0;
    brd = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_rotate();
    t_lsub();
    t_other();
    t_sleep();
    end_sim();
  end
endmodule : rssx_exec_tb
